/* lighting_line_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lighting_consts.svh"
// Summary of operation
// - line one setpoint commands carry the effective transition time
// - joint control from switch two locks line one time, uses line two's
// - startup level written goes to line one ballasts; resets to 254
// - fault level written goes to line one ballasts; resets to 254
// - 32-bit read-only count of valid frames received on line two
// - 32-bit read-only count of erroneous frames received on line two
// - 32-bit read-only count of frames sent on line two
// - control bit 0 reads 1 while line two lit, 0 while dark
// - host clearing bit 0 sends broadcast off on line two
// - host setting bit 0 sends broadcast recall last scene
// - rising edge of bit 1 broadcasts recall last scene
// - rising edge of bit 2 broadcasts off
// - bit 3 gates presence sensor two; resets to 1
// - bit 4 disables switch two dimming, leaving on and off
// - broadcast level 0 to 254 sent to all line two ballasts; resets 0
// - step rate code sets switch fade speed, 358 down to 2.8 steps/s
// - step rate code 0 to 15, 0 no fade, reset default 7
// - joint control from switch one locks line two rate, uses line one's

module lighting_line_control_regs
    import lighting_pkg::*;
#(
    parameter int CLK_HZ = `CLOCK_HZ
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire reg_req_s host_req,
    output logic [15:0] host_rdata,
    input wire logic line2_rx_valid,
    input wire logic line2_rx_error,
    input wire logic line2_tx_done,
    output logic line2_cmd_valid,
    input wire logic line2_cmd_ready,
    output line_cmd_s line2_cmd,
    output logic line1_cmd_valid,
    input wire logic line1_cmd_ready,
    output line_cmd_s line1_cmd,
    input wire logic line1_single_level_set,
    input wire logic [7:0] line1_setpoint,
    input wire logic [3:0] line2_transition_time,
    input wire logic [3:0] line1_step_rate_code,
    input wire logic joint_via_switch_input_two,
    input wire logic joint_via_switch_input_one,
    input wire logic presence_input2_raw,
    output logic presence_input2_effective,
    input wire logic switch2_dim_up,
    input wire logic switch2_dim_down,
    output logic switch2_dim_disable
);

    logic [31:0] counts [3];
    logic [2:0] count_evt;
    logic [4:0] ctl;
    logic [4:0] next_ctl;
    logic [7:0] level;
    logic [7:0] next_level;
    logic [3:0] rate_code;
    logic [3:0] next_rate_code;
    logic [3:0] line1_transition_time;
    logic [3:0] next_transition;
    logic [7:0] startup_level;
    logic [7:0] next_startup;
    logic [7:0] fault_level;
    logic [7:0] next_fault;
    logic pend_dark, pend_recall, pend_level;
    logic next_pend_dark, next_pend_recall, next_pend_level;
    logic pend_start, pend_fault, pend_setp;
    logic next_pend_start, next_pend_fault, next_pend_setp;
    logic [7:0] setp;
    logic [7:0] next_setp;
    logic [15:0] next_rdata;
    logic wr_ctl, dim_run, dim_step, acc2, acc1;
    logic [3:0] eff_rate;
    logic [3:0] eff_time1;

    assign count_evt = {line2_tx_done, line2_rx_error, line2_rx_valid};

    // one wrapping counter per frame event
    for (genvar i = 0; i < 3; i++)
    begin : g_count
        logic [31:0] next_c;
        always_comb
        begin
            next_c = counts[i] + {31'h0, count_evt[i]};
        end
        always_ff @(posedge clock or negedge arst_n)
        begin
            if (!arst_n)
            begin
                counts[i] <= 32'h0;
            end
            else
            begin
                counts[i] <= next_c;
            end
        end
    end

    assign wr_ctl = host_req.wr && host_req.addr == `OFS_CONTROL_BITS;
    assign switch2_dim_disable = ctl[`CTL_DIM_OFF_BIT];
    assign dim_run = (switch2_dim_up ^ switch2_dim_down)
        && !switch2_dim_disable;
    assign eff_rate = joint_via_switch_input_one ? line1_step_rate_code
        : rate_code;
    assign eff_time1 = joint_via_switch_input_two ? line2_transition_time
        : line1_transition_time;
    assign acc2 = line2_cmd_valid && line2_cmd_ready;
    assign acc1 = line1_cmd_valid && line1_cmd_ready;

    fade_step_timer #(
        .CLK_HZ(CLK_HZ)
    ) u_timer (
        .clock(clock),
        .arst_n(arst_n),
        .run(dim_run),
        .code(eff_rate),
        .step(dim_step)
    );

    // line two command queue; off outranks recall outranks level
    always_comb
    begin
        line2_cmd_valid = pend_dark || pend_recall || pend_level;
        line2_cmd.fade = line2_transition_time;
        line2_cmd.value = level;
        if (pend_dark)
        begin
            line2_cmd.code = CMD_DARK;
        end
        else if (pend_recall)
        begin
            line2_cmd.code = CMD_RECALL;
        end
        else
        begin
            line2_cmd.code = CMD_LEVEL;
        end
        line1_cmd_valid = pend_start || pend_fault || pend_setp;
        line1_cmd.fade = eff_time1;
        if (pend_start)
        begin
            line1_cmd.code = CMD_STORE_STARTUP;
            line1_cmd.value = startup_level;
        end
        else if (pend_fault)
        begin
            line1_cmd.code = CMD_STORE_FAULT;
            line1_cmd.value = fault_level;
        end
        else
        begin
            line1_cmd.code = CMD_SETPOINT;
            line1_cmd.value = setp;
        end
    end

    always_comb
    begin
        logic [4:0] w;
        logic take2;
        logic take1;
        w = host_req.wdata[4:0];
        take2 = acc2;
        take1 = acc1;
        next_ctl = ctl;
        next_level = level;
        next_rate_code = rate_code;
        next_transition = line1_transition_time;
        next_startup = startup_level;
        next_fault = fault_level;
        next_setp = setp;
        // a new request in the accept cycle stays pending
        next_pend_dark = pend_dark && !(take2 && line2_cmd.code == CMD_DARK);
        next_pend_recall = pend_recall
            && !(take2 && line2_cmd.code == CMD_RECALL);
        next_pend_level = pend_level
            && !(take2 && line2_cmd.code == CMD_LEVEL);
        next_pend_start = pend_start && !take1;
        next_pend_fault = pend_fault && !(take1 && !pend_start);
        next_pend_setp = pend_setp
            && !(take1 && line1_cmd.code == CMD_SETPOINT);
        if (take2 && line2_cmd.code == CMD_DARK)
        begin
            next_ctl[`CTL_LIT_BIT] = 1'b0;
        end
        if (take2 && line2_cmd.code == CMD_RECALL)
        begin
            next_ctl[`CTL_LIT_BIT] = 1'b1;
        end
        if (wr_ctl)
        begin
            if (!w[`CTL_LIT_BIT] && ctl[`CTL_LIT_BIT])
            begin
                next_pend_dark = 1'b1;
            end
            if (w[`CTL_LIT_BIT] && !ctl[`CTL_LIT_BIT])
            begin
                next_pend_recall = 1'b1;
            end
            if (w[`CTL_RECALL_BIT] && !ctl[`CTL_RECALL_BIT])
            begin
                next_pend_recall = 1'b1;
            end
            if (w[`CTL_DARK_BIT] && !ctl[`CTL_DARK_BIT])
            begin
                next_pend_dark = 1'b1;
            end
            // lit flag follows accepted commands, never the write itself
            next_ctl[4:1] = w[4:1];
        end
        if (host_req.wr)
        begin
            unique case (host_req.addr)
                `OFS_BROADCAST_LEVEL:
                begin
                    next_level = host_req.wdata[7:0] > `LEVEL_MAX
                        ? `LEVEL_MAX : host_req.wdata[7:0];
                    next_pend_level = 1'b1;
                end
                `OFS_STEP_RATE_CODE:
                begin
                    if (!joint_via_switch_input_one)
                    begin
                        next_rate_code = host_req.wdata[3:0];
                    end
                end
                `OFS_TRANSITION_TIME:
                begin
                    if (!joint_via_switch_input_two)
                    begin
                        next_transition = host_req.wdata[3:0];
                    end
                end
                `OFS_STARTUP_LEVEL:
                begin
                    next_startup = host_req.wdata[7:0];
                    next_pend_start = 1'b1;
                end
                `OFS_FAULT_LEVEL:
                begin
                    next_fault = host_req.wdata[7:0];
                    next_pend_fault = 1'b1;
                end
                default:
                begin
                end
            endcase
        end
        else if (dim_run && (dim_step || eff_rate == 4'h0))
        begin
            // code 0 jumps straight to the end of the range
            if (switch2_dim_up && level != `LEVEL_MAX)
            begin
                next_level = eff_rate == 4'h0 ? `LEVEL_MAX
                    : level + 8'h1;
                next_pend_level = 1'b1;
            end
            else if (switch2_dim_down && level != 8'h0)
            begin
                next_level = eff_rate == 4'h0 ? 8'h0 : level - 8'h1;
                next_pend_level = 1'b1;
            end
        end
        if (line1_single_level_set)
        begin
            next_setp = line1_setpoint;
            next_pend_setp = 1'b1;
        end
    end

    always_comb
    begin
        next_rdata = 16'h0;
        if (host_req.rd)
        begin
            unique case (host_req.addr)
                `OFS_RX_VALID_COUNT: next_rdata = counts[0][15:0];
                `OFS_RX_VALID_COUNT + 16'h1: next_rdata = counts[0][31:16];
                `OFS_RX_ERROR_COUNT: next_rdata = counts[1][15:0];
                `OFS_RX_ERROR_COUNT + 16'h1: next_rdata = counts[1][31:16];
                `OFS_TX_COUNT: next_rdata = counts[2][15:0];
                `OFS_TX_COUNT + 16'h1: next_rdata = counts[2][31:16];
                `OFS_CONTROL_BITS: next_rdata = {11'h0, ctl};
                `OFS_BROADCAST_LEVEL: next_rdata = {8'h0, level};
                `OFS_STEP_RATE_CODE: next_rdata = {12'h0, rate_code};
                `OFS_TRANSITION_TIME:
                    next_rdata = {12'h0, line1_transition_time};
                `OFS_STARTUP_LEVEL: next_rdata = {8'h0, startup_level};
                `OFS_FAULT_LEVEL: next_rdata = {8'h0, fault_level};
                default: next_rdata = 16'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctl <= `RST_CONTROL_BITS;
            level <= `RST_BROADCAST_LEVEL;
            rate_code <= `RST_STEP_RATE_CODE;
            line1_transition_time <= `RST_TRANSITION_TIME;
            startup_level <= `RST_STARTUP_LEVEL;
            fault_level <= `RST_FAULT_LEVEL;
            setp <= 8'h0;
            {pend_dark, pend_recall, pend_level} <= 3'h0;
            {pend_start, pend_fault, pend_setp} <= 3'h0;
            host_rdata <= 16'h0;
            presence_input2_effective <= 1'b0;
        end
        else
        begin
            ctl <= next_ctl;
            level <= next_level;
            rate_code <= next_rate_code;
            line1_transition_time <= next_transition;
            startup_level <= next_startup;
            fault_level <= next_fault;
            setp <= next_setp;
            {pend_dark, pend_recall, pend_level} <=
                {next_pend_dark, next_pend_recall, next_pend_level};
            {pend_start, pend_fault, pend_setp} <=
                {next_pend_start, next_pend_fault, next_pend_setp};
            host_rdata <= next_rdata;
            presence_input2_effective <= presence_input2_raw
                && ctl[`CTL_PRESENCE_BIT];
        end
    end

    sequence s_clear_lit;
        wr_ctl && ctl[0] && !host_req.wdata[0];
    endsequence

    a_lit_clear_off: assert property (@(posedge clock) disable iff (!arst_n)
        s_clear_lit |=> pend_dark)
        else $error("clearing bit 0 did not queue off");
    a_lit_set_recall: assert property (@(posedge clock) disable iff (!arst_n)
        wr_ctl && !ctl[0] && host_req.wdata[0] |=> pend_recall)
        else $error("setting bit 0 did not queue recall");
    a_recall_edge: assert property (@(posedge clock) disable iff (!arst_n)
        wr_ctl && !ctl[1] && host_req.wdata[1] |=> pend_recall)
        else $error("bit 1 edge lost");
    a_dark_edge: assert property (@(posedge clock) disable iff (!arst_n)
        wr_ctl && !ctl[2] && host_req.wdata[2] |=> pend_dark)
        else $error("bit 2 edge lost");
    a_lit_follows: assert property (@(posedge clock) disable iff (!arst_n)
        acc2 && line2_cmd.code == CMD_DARK && !wr_ctl |=> !ctl[0])
        else $error("lit flag not cleared by off");
    a_rx_count_step: assert property (@(posedge clock) disable iff (!arst_n)
        line2_rx_valid |=> counts[0] == $past(counts[0]) + 32'h1)
        else $error("valid frame count wrong");
    a_err_count_step: assert property (@(posedge clock) disable iff (!arst_n)
        !line2_rx_error |=> counts[1] == $past(counts[1]))
        else $error("error count moved without event");
    a_tx_count_step: assert property (@(posedge clock) disable iff (!arst_n)
        line2_tx_done |=> counts[2] == $past(counts[2]) + 32'h1)
        else $error("tx count wrong");
    a_presence_gate: assert property (@(posedge clock) disable iff (!arst_n)
        !ctl[3] |=> !presence_input2_effective)
        else $error("presence passed while blocked");
    a_fade_lock: assert property (@(posedge clock) disable iff (!arst_n)
        line1_cmd_valid && joint_via_switch_input_two
        |-> line1_cmd.fade == line2_transition_time)
        else $error("line one fade not taken from line two");
    a_rate_lock: assert property (@(posedge clock) disable iff (!arst_n)
        joint_via_switch_input_one |=> $stable(rate_code))
        else $error("locked rate code changed");
    a_startup_store: assert property (@(posedge clock) disable iff (!arst_n)
        host_req.wr && host_req.addr == `OFS_STARTUP_LEVEL
        |=> line1_cmd_valid && line1_cmd.code == CMD_STORE_STARTUP)
        else $error("startup level not sent");
    a_level_range: assert property (@(posedge clock) disable iff (!arst_n)
        level <= `LEVEL_MAX)
        else $error("broadcast level above 254");

endmodule // lighting_line_control_regs
`default_nettype wire

/* lighting_consts.svh */
`ifndef LIGHTING_CONSTS_SVH
`define LIGHTING_CONSTS_SVH

`define CLOCK_HZ 40000000

`define OFS_RX_VALID_COUNT 16'h7617
`define OFS_RX_ERROR_COUNT 16'h761f
`define OFS_TX_COUNT 16'h7627
`define OFS_CONTROL_BITS 16'h9d3f
`define OFS_BROADCAST_LEVEL 16'h9d4b
`define OFS_STEP_RATE_CODE 16'h9e0f
`define OFS_TRANSITION_TIME 16'h9e12
`define OFS_STARTUP_LEVEL 16'h9e16
`define OFS_FAULT_LEVEL 16'h9e1a

`define CTL_LIT_BIT 0
`define CTL_RECALL_BIT 1
`define CTL_DARK_BIT 2
`define CTL_PRESENCE_BIT 3
`define CTL_DIM_OFF_BIT 4

`define RST_CONTROL_BITS 5'h08
`define RST_BROADCAST_LEVEL 8'h00
`define RST_STEP_RATE_CODE 4'h7
`define RST_TRANSITION_TIME 4'h0
`define RST_STARTUP_LEVEL 8'hfe
`define RST_FAULT_LEVEL 8'hfe
`define LEVEL_MAX 8'hfe

// step rates in tenths of a step per second, codes 1 to 15
`define RATE10_C1 3580
`define RATE10_C2 2530
`define RATE10_C3 1790
`define RATE10_C4 1270
`define RATE10_C5 894
`define RATE10_C6 633
`define RATE10_C7 447
`define RATE10_C8 316
`define RATE10_C9 224
`define RATE10_C10 158
`define RATE10_C11 112
`define RATE10_C12 79
`define RATE10_C13 56
`define RATE10_C14 40
`define RATE10_C15 28

`endif

/* lighting_pkg.sv */
package lighting_pkg;

    typedef enum logic [2:0] {
        CMD_DARK = 3'h0,
        CMD_RECALL = 3'h1,
        CMD_LEVEL = 3'h2,
        CMD_STORE_STARTUP = 3'h3,
        CMD_STORE_FAULT = 3'h4,
        CMD_SETPOINT = 3'h5
    } line_cmd_e;

    typedef struct packed {
        line_cmd_e code;
        logic [7:0] value;
        logic [3:0] fade;
    } line_cmd_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

/* fade_step_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lighting_consts.svh"

module fade_step_timer
    import lighting_pkg::*;
#(
    parameter int CLK_HZ = `CLOCK_HZ
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic run,
    input wire logic [3:0] code,
    output logic step
);

    function automatic int unsigned rate10(input int c);
        case (c)
            1: rate10 = `RATE10_C1;
            2: rate10 = `RATE10_C2;
            3: rate10 = `RATE10_C3;
            4: rate10 = `RATE10_C4;
            5: rate10 = `RATE10_C5;
            6: rate10 = `RATE10_C6;
            7: rate10 = `RATE10_C7;
            8: rate10 = `RATE10_C8;
            9: rate10 = `RATE10_C9;
            10: rate10 = `RATE10_C10;
            11: rate10 = `RATE10_C11;
            12: rate10 = `RATE10_C12;
            13: rate10 = `RATE10_C13;
            14: rate10 = `RATE10_C14;
            default: rate10 = `RATE10_C15;
        endcase
    endfunction

    // longest spacing rounds down, never below two cycles
    function automatic logic [31:0] period(input int c);
        longint unsigned p;
        p = (longint'(CLK_HZ) * 10) / rate10(c);
        if (p < 2)
        begin
            p = 2;
        end
        period = p[31:0];
    endfunction

    logic [31:0] period_table [16];
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_step;

    for (genvar i = 0; i < 16; i++)
    begin : g_period
        assign period_table[i] = period(i);
    end

    always_comb
    begin
        next_count = 32'h0;
        next_step = 1'b0;
        if (run && code != 4'h0)
        begin
            if (count >= period_table[code] - 32'h1)
            begin
                next_step = 1'b1;
            end
            else
            begin
                next_count = count + 32'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= 32'h0;
            step <= 1'b0;
        end
        else
        begin
            count <= next_count;
            step <= next_step;
        end
    end

    a_step_single: assert property (@(posedge clock) disable iff (!arst_n)
        step |=> !step)
        else $error("step pulse lasted more than one cycle");

endmodule // fade_step_timer
`default_nettype wire

/* line_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module line_partner (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic valid2,
    input wire logic valid1,
    output logic ready2,
    output logic ready1,
    output logic tx_done
);
    logic phase;

    // slow mode stalls every other cycle, the two lines out of step
    assign ready2 = !slow || phase;
    assign ready1 = !slow || !phase;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase <= 1'b0;
            tx_done <= 1'b0;
        end
        else
        begin
            phase <= !phase;
            // one frame goes out per accepted line two command
            tx_done <= valid2 && ready2;
        end
    end
endmodule // line_partner

`default_nettype wire

/* tb_lighting_line_control_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lighting_consts.svh"

module tb_lighting_line_control_regs
    import lighting_pkg::*;
;
    localparam logic [15:0] CB = `OFS_CONTROL_BITS;
    localparam logic [15:0] LV = `OFS_BROADCAST_LEVEL;
    localparam logic [15:0] RC = `OFS_STEP_RATE_CODE;
    localparam logic [15:0] TT = `OFS_TRANSITION_TIME;
    localparam logic [15:0] SU = `OFS_STARTUP_LEVEL;
    localparam logic [15:0] FL = `OFS_FAULT_LEVEL;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    reg_req_s req = '0;
    logic [15:0] rdata;
    logic rxv = 1'b0, rxe = 1'b0, sls = 1'b0, slow = 1'b0;
    logic j1 = 1'b0, j2 = 1'b0, praw = 1'b0, up = 1'b0, dn = 1'b0;
    logic txd, v1, v2, r1, r2, pe, dd;
    logic [7:0] sp = 8'h0;
    logic [3:0] tt2 = 4'h2, rc1 = 4'h5;
    line_cmd_s c1, c2;
    line_cmd_s q1[$], q2[$];
    logic [31:0] seed = 32'h8d23, q;
    int miscompares = 0, checked = 0, nrx = 0, ner = 0, ntx = 0, lit = 0, v;

    always #12.5 clock = !clock;

    lighting_line_control_regs #(.CLK_HZ(4000)) dut (
        .clock(clock), .arst_n(arst_n), .host_req(req), .host_rdata(rdata),
        .line2_rx_valid(rxv), .line2_rx_error(rxe), .line2_tx_done(txd),
        .line2_cmd_valid(v2), .line2_cmd_ready(r2), .line2_cmd(c2),
        .line1_cmd_valid(v1), .line1_cmd_ready(r1), .line1_cmd(c1),
        .line1_single_level_set(sls), .line1_setpoint(sp),
        .line2_transition_time(tt2), .line1_step_rate_code(rc1),
        .joint_via_switch_input_two(j2), .joint_via_switch_input_one(j1),
        .presence_input2_raw(praw), .presence_input2_effective(pe),
        .switch2_dim_up(up), .switch2_dim_down(dn),
        .switch2_dim_disable(dd));

    line_partner far_side (.clock(clock), .arst_n(arst_n), .slow(slow),
        .valid2(v2), .valid1(v1), .ready2(r2), .ready1(r1), .tx_done(txd));

    // sampled mid-cycle, away from the edge that updates the design
    always @(negedge clock)
    begin
        if (rxv) nrx++;
        if (rxe) ner++;
        if (v1 && r1) q1.push_back(c1);
        if (v2 && r2)
        begin
            q2.push_back(c2);
            ntx++;
            if (c2.code == CMD_DARK) lit = 0;
            if (c2.code == CMD_RECALL) lit = 1;
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic acc(input logic [15:0] a, d, input logic w);
        @(posedge clock);
        #1 req = '{a, d, w, !w};
        @(posedge clock);
        #1 q = 32'(rdata);
        req = '0;
    endtask

    task automatic rd(input string n, input logic [15:0] a, input int e);
        acc(a, 16'h0, 1'b0);
        chk(n, q, e);
    endtask

    task automatic rd32(input string n, input logic [15:0] a, input int e);
        rd(n, a, e & 32'hffff);
        rd(n, a + 16'h1, (e >> 16) & 32'hffff);
    endtask

    task automatic expc(input bit l1, input line_cmd_e c, input int v, f);
        line_cmd_s x;
        for (int i = 0; i < 40 && (l1 ? q1.size() : q2.size()) == 0; i++)
        begin
            @(posedge clock);
            #1;
        end
        if ((l1 ? q1.size() : q2.size()) == 0)
        begin
            miscompares++;
            complete_run();
        end
        x = l1 ? q1.pop_front() : q2.pop_front();
        chk("cmd code", 32'(x.code), 32'(c));
        if (v >= 0) chk("cmd value", 32'(x.value), v);
        chk("cmd fade", 32'(x.fade), f);
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    initial
    begin
        repeat (100000) @(posedge clock);
        miscompares++;
        complete_run();
    end

    initial
    begin
        hold(8);
        arst_n = 1'b1;
        rd("control", CB, 32'h8);
        rd("level", LV, 32'h0);
        rd("rate", RC, 32'h7);
        rd("startup", SU, 32'hfe);
        rd("fault", FL, 32'hfe);
        rd("time", TT, 32'h0);
        rd("unmapped", 16'h1234, 32'h0);
        acc(`OFS_RX_VALID_COUNT, 16'h5555, 1'b1);
        rd32("rx count", `OFS_RX_VALID_COUNT, 0);
        $display("end reset");
        acc(TT, 16'h5, 1'b1);
        v = int'(rnd() % 255);
        acc(SU, 16'(v), 1'b1);
        expc(1, CMD_STORE_STARTUP, v, 5);
        rd("startup", SU, v);
        v = int'(rnd() % 255);
        acc(FL, 16'(v), 1'b1);
        expc(1, CMD_STORE_FAULT, v, 5);
        j2 = 1'b1;
        tt2 = 4'h9;
        acc(TT, 16'h3, 1'b1);
        rd("time", TT, 32'h5);
        sp = 8'(v);
        sls = 1'b1;
        hold(1);
        sls = 1'b0;
        expc(1, CMD_SETPOINT, v, 9);
        j2 = 1'b0;
        $display("end line one");
        slow = 1'b1;
        acc(CB, 16'h9, 1'b1);
        expc(0, CMD_RECALL, -1, tt2);
        rd("lit", CB, 8 | lit);
        acc(CB, 16'h8, 1'b1);
        expc(0, CMD_DARK, -1, tt2);
        rd("dark", CB, 8 | lit);
        acc(CB, 16'ha, 1'b1);
        expc(0, CMD_RECALL, -1, tt2);
        acc(CB, 16'hb, 1'b1);
        acc(CB, 16'hd, 1'b1);
        expc(0, CMD_DARK, -1, tt2);
        acc(CB, 16'h8, 1'b1);
        acc(CB, 16'hf, 1'b1);
        expc(0, CMD_DARK, -1, tt2);
        expc(0, CMD_RECALL, -1, tt2);
        hold(10);
        chk("extra cmds", 32'(q2.size()), 0);
        rd("control", CB, 32'he | lit);
        acc(CB, 16'h9, 1'b1);
        slow = 1'b0;
        $display("end control");
        v = int'(rnd() % 255);
        acc(LV, 16'(v), 1'b1);
        expc(0, CMD_LEVEL, v, tt2);
        acc(LV, 16'h0ff, 1'b1);
        expc(0, CMD_LEVEL, 254, tt2);
        rd("level", LV, 254);
        for (int i = 0; i < 8; i++)
        begin
            acc(CB, 16'(lit | (i % 2) << 3 | (i / 2 % 2) << 4), 1'b1);
            praw = 1'(i / 4);
            hold(2);
            chk("presence", 32'(pe), (i / 4) & (i % 2));
            chk("dim off", 32'(dd), i / 2 % 2);
        end
        acc(RC, 16'h3, 1'b1);
        rd("rate", RC, 32'h3);
        j1 = 1'b1;
        rc1 = 4'h0;
        acc(RC, 16'h9, 1'b1);
        rd("rate", RC, 32'h3);
        dn = 1'b1;
        hold(20);
        dn = 1'b0;
        rd("no dim", LV, 254);
        acc(CB, 16'(8 | lit), 1'b1);
        dn = 1'b1;
        hold(10);
        dn = 1'b0;
        rd("jump", LV, 0);
        j1 = 1'b0;
        acc(RC, 16'h1, 1'b1);
        up = 1'b1;
        hold(100);
        up = 1'b0;
        acc(LV, 16'h0, 1'b0);
        chk("ramp", 32'(q >= 7 && q <= 10), 1);
        q2.delete();
        $display("end dimming");
        for (int i = 0; i < 64; i++)
        begin
            seed = rnd();
            rxv = seed[0];
            rxe = seed[1];
            hold(1);
        end
        rxv = 1'b0;
        rxe = 1'b0;
        hold(4);
        rd32("rx count", `OFS_RX_VALID_COUNT, nrx);
        rd32("err count", `OFS_RX_ERROR_COUNT, ner);
        rd32("tx count", `OFS_TX_COUNT, ntx);
        $display("end counters");
        complete_run();
    end
endmodule // tb_lighting_line_control_regs

`default_nettype wire
